// >>> include/eip_consts.vh
// constants for the external interrupt pin configuration block
`ifndef EIP_CONSTS_VH
`define EIP_CONSTS_VH

// special-function address and the pages that reach it
`define EIP_CFG_ADDR        8'hE4
`define EIP_PAGE_LOW        8'h00
`define EIP_PAGE_HIGH       8'h10

// reset value of the whole configuration register
`define EIP_CFG_RESET       8'h01

// reset value of each field on its own
`define EIP_ONE_POL_RESET   1'h0
`define EIP_ONE_SEL_RESET   3'h0
`define EIP_ZERO_POL_RESET  1'h0
`define EIP_ZERO_SEL_RESET  3'h1

// field positions
`define EIP_ONE_POL_BIT     7
`define EIP_ONE_SEL_MSB     6
`define EIP_ONE_SEL_LSB     4
`define EIP_ZERO_POL_BIT    3
`define EIP_ZERO_SEL_MSB    2
`define EIP_ZERO_SEL_LSB    0

// value returned for a read of an address this block does not own
`define EIP_RDATA_IDLE      8'h00

`endif

// >>> rtl/eip_irq_channel.v
// one external interrupt channel: pin selection and polarity adjustment
`timescale 1ns/100ps

module eip_irq_channel #(
    parameter PINS    = 8,
    parameter SEL_W   = 3
) (
    input  wire             clk,
    input  wire             srst,
    input  wire [PINS-1:0]  pin_level,
    input  wire [SEL_W-1:0] pin_select,
    input  wire             polarity,
    output reg              request
);

    wire next_request;

    // polarity 0 means the pin is active low, so invert; 1 passes it as is
    assign next_request = pin_level[pin_select] ~^ polarity;

    // registered so the request is a clean flop output to the detector
    always @(posedge clk) begin
        if (srst) begin
            request <= 1'h0;
        end else begin
            request <= next_request;
        end
    end

endmodule // eip_irq_channel

// >>> rtl/eip_ext_irq_cfg.v
// external interrupt pin configuration register and request generation
//
// Functional notes
// - second input polarity from bit 7, reset 0
// - bits 6:4 pick second input pin, reset 0
// - second input sampled without disturbing crossbar peripherals
// - first input polarity from bit 3, reset 0
// - bits 2:0 pick first input pin, reset 1
// - first input observed without altering crossbar routing
// - crossbar never grants a skipped pin to peripherals
// - register at address E4, pages 00 and 10
`timescale 1ns/100ps
`include "eip_consts.vh"

module eip_ext_irq_cfg #(
    parameter PINS  = 8,
    parameter SEL_W = 3
) (
    // clock and reset
    input  wire             clk,
    input  wire             srst,
    // special-function register access from the core
    input  wire [7:0]       sfr_addr,
    input  wire [7:0]       sfr_page,
    input  wire             sfr_wr,
    input  wire             sfr_rd,
    input  wire [7:0]       sfr_wdata,
    output reg  [7:0]       sfr_rdata,
    output wire             sfr_hit,
    // port 0 pin levels, asynchronous to clk
    input  wire [PINS-1:0]  port0_pin,
    // crossbar side: skip settings and peripheral pin requests
    input  wire [PINS-1:0]  xbar_skip,
    input  wire [PINS-1:0]  xbar_periph_req,
    output reg  [PINS-1:0]  xbar_periph_grant,
    // configuration fields seen by the rest of the interrupt logic
    output wire             irq_one_polarity,
    output wire [SEL_W-1:0] irq_one_pin_select,
    output wire             irq_zero_polarity,
    output wire [SEL_W-1:0] irq_zero_pin_select,
    // active-high requests toward edge or level detection
    output wire             ext_irq_zero,
    output wire             ext_irq_one
);

    ////////////////////////////////////////////////////////////////////////
    // configuration register

    // one register per field, so each field keeps its own reset value
    reg              one_pol;
    reg  [SEL_W-1:0] one_sel;
    reg              zero_pol;
    reg  [SEL_W-1:0] zero_sel;
    reg              next_one_pol;
    reg  [SEL_W-1:0] next_one_sel;
    reg              next_zero_pol;
    reg  [SEL_W-1:0] next_zero_sel;
    wire [7:0]       cfg;
    wire             page_ok;
    wire             addr_ok;
    wire             cfg_wr;
    wire             cfg_rd;

    // the register answers on two pages only; any other page is ignored
    assign page_ok = (sfr_page == `EIP_PAGE_LOW) || (sfr_page == `EIP_PAGE_HIGH);
    assign addr_ok = (sfr_addr == `EIP_CFG_ADDR);
    assign sfr_hit = page_ok && addr_ok;
    assign cfg_wr  = sfr_hit && sfr_wr;
    assign cfg_rd  = sfr_hit && sfr_rd;

    // second input polarity; all eight bits are writable, none reserved
    always @* begin
        if (cfg_wr) begin
            next_one_pol = sfr_wdata[`EIP_ONE_POL_BIT];
        end else begin
            next_one_pol = one_pol;
        end
    end

    // second input pin code
    always @* begin
        if (cfg_wr) begin
            next_one_sel = sfr_wdata[`EIP_ONE_SEL_MSB:`EIP_ONE_SEL_LSB];
        end else begin
            next_one_sel = one_sel;
        end
    end

    // first input polarity
    always @* begin
        if (cfg_wr) begin
            next_zero_pol = sfr_wdata[`EIP_ZERO_POL_BIT];
        end else begin
            next_zero_pol = zero_pol;
        end
    end

    // first input pin code
    always @* begin
        if (cfg_wr) begin
            next_zero_sel = sfr_wdata[`EIP_ZERO_SEL_MSB:`EIP_ZERO_SEL_LSB];
        end else begin
            next_zero_sel = zero_sel;
        end
    end

    // second input comes out of reset active low
    always @(posedge clk) begin
        if (srst) begin
            one_pol <= `EIP_ONE_POL_RESET;
        end else begin
            one_pol <= next_one_pol;
        end
    end

    // second input comes out of reset on pin 0
    always @(posedge clk) begin
        if (srst) begin
            one_sel <= `EIP_ONE_SEL_RESET;
        end else begin
            one_sel <= next_one_sel;
        end
    end

    // first input comes out of reset active low
    always @(posedge clk) begin
        if (srst) begin
            zero_pol <= `EIP_ZERO_POL_RESET;
        end else begin
            zero_pol <= next_zero_pol;
        end
    end

    // first input comes out of reset on pin 1, not on pin 0
    always @(posedge clk) begin
        if (srst) begin
            zero_sel <= `EIP_ZERO_SEL_RESET;
        end else begin
            zero_sel <= next_zero_sel;
        end
    end

    // register image for read back, same bit order as the write data
    assign cfg = {one_pol, one_sel, zero_pol, zero_sel};

    // read data is registered; a read in the write cycle returns the old value
    always @(posedge clk) begin
        if (srst) begin
            sfr_rdata <= `EIP_RDATA_IDLE;
        end else if (cfg_rd) begin
            sfr_rdata <= cfg;
        end else begin
            sfr_rdata <= `EIP_RDATA_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field extraction

    assign irq_one_polarity    = one_pol;
    assign irq_one_pin_select  = one_sel;
    assign irq_zero_polarity   = zero_pol;
    assign irq_zero_pin_select = zero_sel;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser

    reg  [PINS-1:0] pin_meta;
    reg  [PINS-1:0] pin_sync;

    // two stages before any logic; the first is read by the second only.
    // the pins are only sampled here, never driven, so a peripheral
    // that the crossbar placed on the same pin keeps full use of it
    always @(posedge clk) begin
        if (srst) begin
            pin_meta <= {PINS{1'h0}};
            pin_sync <= {PINS{1'h0}};
        end else begin
            pin_meta <= port0_pin;
            pin_sync <= pin_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request channels

    // first external interrupt input
    eip_irq_channel #(
        .PINS       (PINS),
        .SEL_W      (SEL_W)
    ) u_chan_zero (
        .clk        (clk),
        .srst       (srst),
        .pin_level  (pin_sync),
        .pin_select (irq_zero_pin_select),
        .polarity   (irq_zero_polarity),
        .request    (ext_irq_zero)
    );

    // second external interrupt input
    eip_irq_channel #(
        .PINS       (PINS),
        .SEL_W      (SEL_W)
    ) u_chan_one (
        .clk        (clk),
        .srst       (srst),
        .pin_level  (pin_sync),
        .pin_select (irq_one_pin_select),
        .polarity   (irq_one_polarity),
        .request    (ext_irq_one)
    );

    ////////////////////////////////////////////////////////////////////////
    // crossbar skip gating

    // a skipped pin is never handed to a peripheral, which is how software
    // keeps an interrupt pin private; the selection above does not depend
    // on this, the interrupt watches the pin either way
    always @(posedge clk) begin
        if (srst) begin
            xbar_periph_grant <= {PINS{1'h0}};
        end else begin
            xbar_periph_grant <= xbar_periph_req & ~xbar_skip;
        end
    end

endmodule // eip_ext_irq_cfg

// >>> testbench/eip_ext_irq_cfg_asserts.sv
// checks on the irq pin config block
`timescale 1ns/100ps
module eip_ext_irq_cfg_asserts (
    input wire clk, srst, sfr_wr, sfr_rd, sfr_hit, ext_irq_zero, ext_irq_one,
    input wire irq_one_polarity, irq_zero_polarity,
    input wire [2:0] irq_one_pin_select, irq_zero_pin_select,
    input wire [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata, port0_pin,
    input wire [7:0] xbar_skip, xbar_periph_req, xbar_periph_grant);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire [7:0] cfg = {irq_one_polarity, irq_one_pin_select, irq_zero_polarity, irq_zero_pin_select};
    logic [7:0] d1, d2, d3;
    logic [1:0] age;
    // pin seen three edges late; age hides the pipe refill after reset
    always @(posedge clk) begin
        {d3, d2, d1} <= {d2, d1, port0_pin};
        age <= srst ? 2'h0 : age + {1'h0, age != 2'h3};
    end
    chk_one_req: assert property (&age |-> ext_irq_one ==
        (d3[$past(irq_one_pin_select)] ~^ $past(irq_one_polarity))) else $error("req one");
    chk_zero_req: assert property (&age |-> ext_irq_zero ==
        (d3[$past(irq_zero_pin_select)] ~^ $past(irq_zero_polarity))) else $error("req zero");
    chk_one_sel: assert property (sfr_wr && sfr_hit |=>
        irq_one_pin_select == $past(sfr_wdata[6:4])) else $error("sel one");
    chk_zero_sel: assert property (sfr_wr && sfr_hit |=>
        irq_zero_pin_select == $past(sfr_wdata[2:0])) else $error("sel zero");
    chk_pol_write: assert property (sfr_wr && sfr_hit |=>
        {irq_one_polarity, irq_zero_polarity} == $past({sfr_wdata[7], sfr_wdata[3]}))
        else $error("polarity");
    chk_reset_val: assert property ($fell(srst) |-> cfg == 8'h01)
        else $error("reset value");
    chk_page_hit: assert property (sfr_hit ==
        (sfr_addr == 8'hE4 && (sfr_page == 8'h00 || sfr_page == 8'h10))) else $error("decode");
    chk_read_back: assert property (sfr_rdata ==
        ($past(sfr_rd && sfr_hit) ? $past(cfg) : 8'h00)) else $error("read data");
    chk_skip_grant: assert property (&age |-> xbar_periph_grant ==
        $past(xbar_periph_req & ~xbar_skip)) else $error("grant");
    cov_hit_wr: cover property (sfr_wr && sfr_hit);
    cov_miss_rd: cover property (sfr_rd && !sfr_hit);
    cov_zero_rise: cover property ($rose(ext_irq_zero));
endmodule // eip_ext_irq_cfg_asserts
bind eip_ext_irq_cfg eip_ext_irq_cfg_asserts i_chk (.*);

// >>> testbench/eip_pin_model.sv
// random port 0 pin levels
`timescale 1ns/100ps
module eip_pin_model (input wire clk, output logic [7:0] port0_pin = 8'h00);
    // moves at the falling edge so the sync flops never race it
    always @(negedge clk) if ($urandom_range(3) == 0) port0_pin <= 8'($urandom);
endmodule // eip_pin_model

// >>> testbench/eip_ext_irq_cfg_tb_top.sv
// bench for the irq pin config block
`timescale 1ns/100ps
module eip_ext_irq_cfg_tb_top;
    logic clk = '0, srst = '1, sfr_wr = '0, sfr_rd = '0;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, xbar_skip, xbar_periph_req, d, cfg, q[$];
    wire [7:0] sfr_rdata, port0_pin, xbar_periph_grant;
    wire [2:0] irq_one_pin_select, irq_zero_pin_select;
    wire sfr_hit, irq_one_polarity, irq_zero_polarity, ext_irq_zero, ext_irq_one;
    int failures = 0, num_checks = 0;
    eip_ext_irq_cfg i_eip_ext_irq_cfg (.*);
    eip_pin_model i_eip_pin_model (.*);
    always #5 clk = ~clk;
    // read data is looked at one edge after the strobe
    always @(posedge clk) if (sfr_rd) @(negedge clk) cmp(sfr_rdata, q.pop_front());
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        close_out();
    end
    task automatic cmp(input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: read %h not %h", $time, g, e);
        end
    endtask
    // one strobe cycle; the note is made as the strobe rises
    task automatic acc(input logic w, input logic [7:0] p, a);
        @(negedge clk);
        {sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = {w, !w, p, a, d};
        if (a == 8'hE4 && !(p & 8'hEF)) begin
            if (w) cfg = d;
            else q.push_back(cfg);
        end else if (!w) q.push_back(8'h00);
        @(negedge clk);
        {sfr_wr, sfr_rd} = 2'h0;
    endtask
    task automatic close_out;
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // every pin code of both inputs, refused writes, one mid-run reset
    initial begin
        {sfr_addr, sfr_page, sfr_wdata, xbar_skip, xbar_periph_req, cfg} = 48'h01;
        void'($urandom(32'h4E6D651D));
        repeat (8) @(posedge clk);
        @(negedge clk) srst = '0;
        for (int i = 0; i < 64; i++) begin
            d = {1'($urandom), i[2:0], 1'($urandom), i[5:3]};
            acc('1, 8'h20, 8'hE4);
            acc('0, {3'h0, i[0], 4'h0}, 8'hE4);
            acc('1, {3'h0, i[1], 4'h0}, 8'hE4);
            acc('0, 8'h00, 8'hE5);
            {xbar_skip, xbar_periph_req} = 16'($urandom);
            srst = i == 40;
            repeat (12) @(negedge clk);
            srst = '0;
            if (i == 40) cfg = 8'h01;
        end
        close_out();
    end
endmodule // eip_ext_irq_cfg_tb_top
